// >>> logic/ilbw_regs.vh
`ifndef ILBW_REGS_VH
`define ILBW_REGS_VH
`define ILBW_LOG_BASE 9'h180
`define ILBW_LOG_LAST 9'h1be
`define ILBW_PTR_STEP 9'h002
`define ILBW_HW_LOC_WORD 16'h0000
`define ILBW_CNT_MAX 7'h7f
`define ILBW_CNT_ONE 7'h01
`define ILBW_BUSY_BIT 9
`define ILBW_CFG_BUSY_BIT 2
`define ILBW_SRC_HW 2'h0
`define ILBW_SRC_MON 2'h1
`define ILBW_SRC_RT 2'h2
`define ILBW_ADDR_PTR 4'h0
`define ILBW_ADDR_CFG 4'h1
`define ILBW_ADDR_STAT 4'h2
`define ILBW_ADDR_MASK 4'h3
`define ILBW_ADDR_SWRST 4'h4
`define ILBW_ADDR_RAM_SEL 4'h5
`define ILBW_ADDR_RAM_DATA 4'h6
`define ILBW_STAT_W 3
`endif

// >>> logic/ilbw_log_ram.v
`timescale 1ns/1ns
`default_nettype none
module ilbw_log_ram (
  input wire clk_in,
  input wire we_in,
  input wire [5:0] waddr_in,
  input wire [15:0] wdata_in,
  input wire [5:0] raddr_in,
  output reg [15:0] rdata_out
);
  reg [15:0] mem [0:63];
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule
`default_nettype wire

// >>> logic/ilbw_writer.v
// Functional notes
// - log is 64 ram words at 0x0180 to 0x01bf, used circularly
// - every enabled interrupt writes exactly two words; 32 entries retained
// - after the 32nd entry the pointer returns to 0x0180 before the next
// - ident word at even pointer address, location word at next odd address
// - ident word uses the source pending layout; several bits may be set
// - hardware events log a location word of zero
// - monitor events log the command buffer address of the block status word
// - terminal events log the descriptor table entry start address
// - with log_busy_enable set, ident bit 9 reports terminal_was_busy_flag
// - busy alone never produces an entry
// - several causes of one terminal in one message make one entry
// - monitor and terminal causes in one message make separate entries
// - simultaneous causes are ORed so the request line asserts once
// - pointer set to 0x0180 on master reset and software reset
// - pointer upper bits 110, always even, advancing by two per entry
// - 7-bit count in bits 15:9 increments, saturates at 127, clears on read
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ilbw_regs.vh"
module ilbw_writer (
  input wire REF_CLK_IN,
  input wire RST_IN,
  input wire HW_EVENT_IN,
  input wire [15:0] HW_IDENT_IN,
  input wire MON_EVENT_IN,
  input wire [15:0] MON_IDENT_IN,
  input wire [15:0] MON_LOC_IN,
  input wire RT_EVENT_IN,
  input wire [15:0] RT_IDENT_IN,
  input wire [15:0] RT_LOC_IN,
  input wire RT_WAS_BUSY_IN,
  input wire [3:0] ADDR_IN,
  input wire [15:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [15:0] RDATA_OUT,
  output reg IRQ_OUT,
  output reg RAM_WE_OUT,
  output reg [8:0] RAM_ADDR_OUT,
  output reg [15:0] RAM_DATA_OUT
);
  reg [8:0] ptr_reg;
  reg [8:0] ptr_next;
  reg [6:0] cnt_reg;
  reg [6:0] cnt_next;
  reg cfg_busy_reg;
  reg [2:0] stat_reg;
  reg [2:0] stat_next;
  reg [2:0] mask_reg;
  reg [2:0] pend_reg;
  reg [2:0] pend_next;
  reg [15:0] hw_id_reg;
  reg [15:0] mon_id_reg;
  reg [15:0] mon_loc_reg;
  reg [15:0] rt_id_reg;
  reg [15:0] rt_loc_reg;
  reg [1:0] src_reg;
  reg phase_reg;
  reg busy_reg;
  reg [5:0] dbg_addr_reg;
  reg [15:0] rdata_next;
  wire [15:0] ram_rdata;
  wire sw_rst = WR_IN && (ADDR_IN == `ILBW_ADDR_SWRST);
  wire ptr_read = RD_IN && (ADDR_IN == `ILBW_ADDR_PTR);
  wire stat_read = RD_IN && (ADDR_IN == `ILBW_ADDR_STAT);
  wire [15:0] ev_id = (src_reg == `ILBW_SRC_HW) ? hw_id_reg :
                      (src_reg == `ILBW_SRC_MON) ? mon_id_reg : rt_id_reg;
  wire [15:0] ev_loc = (src_reg == `ILBW_SRC_HW) ? `ILBW_HW_LOC_WORD :
                       (src_reg == `ILBW_SRC_MON) ? mon_loc_reg : rt_loc_reg;
  wire entry_done = busy_reg && phase_reg;
  // busy flag only rides along inside a real terminal entry, never starts one
  wire [15:0] rt_id_in_busy = cfg_busy_reg ?
    {RT_IDENT_IN[15:`ILBW_BUSY_BIT+1], RT_WAS_BUSY_IN, RT_IDENT_IN[`ILBW_BUSY_BIT-1:0]} :
    RT_IDENT_IN;
  ilbw_log_ram u_ram (
    .clk_in(REF_CLK_IN),
    .we_in(RAM_WE_OUT),
    .waddr_in(RAM_ADDR_OUT[5:0]),
    .wdata_in(RAM_DATA_OUT),
    .raddr_in(dbg_addr_reg),
    .rdata_out(ram_rdata)
  );
  // pick next pending source: hardware, monitor, terminal
  reg [1:0] pick;
  always @* begin
    pick = `ILBW_SRC_RT;
    if (pend_reg[0]) begin
      pick = `ILBW_SRC_HW;
    end else if (pend_reg[1]) begin
      pick = `ILBW_SRC_MON;
    end
  end
  always @* begin
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    if (entry_done) begin
      if (ptr_reg == `ILBW_LOG_LAST) begin
        ptr_next = `ILBW_LOG_BASE;
      end else begin
        ptr_next = ptr_reg + `ILBW_PTR_STEP;
      end
    end
    if (ptr_read) begin
      cnt_next = 7'h00;
    end
    // a completing entry during the read survives as a count of one
    if (entry_done) begin
      if (ptr_read) begin
        cnt_next = `ILBW_CNT_ONE;
      end else if (cnt_reg != `ILBW_CNT_MAX) begin
        cnt_next = cnt_reg + `ILBW_CNT_ONE;
      end
    end
    if (sw_rst) begin
      ptr_next = `ILBW_LOG_BASE;
    end
  end
  always @* begin
    pend_next = pend_reg;
    if (!busy_reg && (pend_reg != 3'h0)) begin
      pend_next[pick] = 1'b0;
    end
    // separate flags per source give each source its own entry
    if (HW_EVENT_IN) begin
      pend_next[0] = 1'b1;
    end
    if (MON_EVENT_IN) begin
      pend_next[1] = 1'b1;
    end
    if (RT_EVENT_IN) begin
      pend_next[2] = 1'b1;
    end
  end
  always @* begin
    stat_next = stat_reg;
    if (stat_read) begin
      stat_next = 3'h0;
    end
    // set wins over the read clear
    stat_next = stat_next | {RT_EVENT_IN, MON_EVENT_IN, HW_EVENT_IN};
  end
  always @* begin
    rdata_next = 16'h0000;
    if (RD_IN) begin
      if (ADDR_IN == `ILBW_ADDR_PTR) begin
        rdata_next = {cnt_reg, ptr_reg};
      end else if (ADDR_IN == `ILBW_ADDR_CFG) begin
        rdata_next = {13'h0000, cfg_busy_reg, 2'h0};
      end else if (ADDR_IN == `ILBW_ADDR_STAT) begin
        rdata_next = {13'h0000, stat_reg};
      end else if (ADDR_IN == `ILBW_ADDR_MASK) begin
        rdata_next = {13'h0000, mask_reg};
      end else if (ADDR_IN == `ILBW_ADDR_RAM_SEL) begin
        rdata_next = {10'h000, dbg_addr_reg};
      end else if (ADDR_IN == `ILBW_ADDR_RAM_DATA) begin
        // ram output is registered off the held index, so it has settled by the read
        rdata_next = ram_rdata;
      end
    end
  end
  always @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ptr_reg <= `ILBW_LOG_BASE;
      cnt_reg <= 7'h00;
      cfg_busy_reg <= 1'b0;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      pend_reg <= 3'h0;
      hw_id_reg <= 16'h0000;
      mon_id_reg <= 16'h0000;
      mon_loc_reg <= 16'h0000;
      rt_id_reg <= 16'h0000;
      rt_loc_reg <= 16'h0000;
      src_reg <= `ILBW_SRC_HW;
      phase_reg <= 1'b0;
      busy_reg <= 1'b0;
      dbg_addr_reg <= 6'h00;
      RDATA_OUT <= 16'h0000;
      IRQ_OUT <= 1'b0;
      RAM_WE_OUT <= 1'b0;
      RAM_ADDR_OUT <= `ILBW_LOG_BASE;
      RAM_DATA_OUT <= 16'h0000;
    end else begin
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      stat_reg <= stat_next;
      pend_reg <= pend_next;
      RDATA_OUT <= rdata_next;
      IRQ_OUT <= |(stat_next & mask_reg);
      if (WR_IN && (ADDR_IN == `ILBW_ADDR_CFG)) begin
        cfg_busy_reg <= WDATA_IN[`ILBW_CFG_BUSY_BIT];
      end
      if (WR_IN && (ADDR_IN == `ILBW_ADDR_MASK)) begin
        mask_reg <= WDATA_IN[2:0];
      end
      if (WR_IN && (ADDR_IN == `ILBW_ADDR_RAM_SEL)) begin
        dbg_addr_reg <= WDATA_IN[5:0];
      end
      // one event carries all causes of a message ORed in its word
      if (HW_EVENT_IN) begin
        hw_id_reg <= HW_IDENT_IN;
      end
      if (MON_EVENT_IN) begin
        mon_id_reg <= MON_IDENT_IN;
        mon_loc_reg <= MON_LOC_IN;
      end
      if (RT_EVENT_IN) begin
        rt_id_reg <= rt_id_in_busy;
        rt_loc_reg <= RT_LOC_IN;
      end
      RAM_WE_OUT <= 1'b0;
      if (busy_reg) begin
        if (!phase_reg) begin
          phase_reg <= 1'b1;
          RAM_WE_OUT <= 1'b1;
          RAM_ADDR_OUT <= ptr_reg;
          RAM_DATA_OUT <= ev_id;
        end else begin
          phase_reg <= 1'b0;
          busy_reg <= 1'b0;
          RAM_WE_OUT <= 1'b1;
          RAM_ADDR_OUT <= ptr_reg | 9'h001;
          RAM_DATA_OUT <= ev_loc;
        end
      end else if (pend_reg != 3'h0) begin
        busy_reg <= 1'b1;
        src_reg <= pick;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/ilbw_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side view of the log region; the host only ever reads what was written
module ilbw_host_model (
  input wire logic REF_CLK_IN,
  input wire logic RAM_WE_OUT,
  input wire logic [8:0] RAM_ADDR_OUT,
  input wire logic [15:0] RAM_DATA_OUT
);
  logic [15:0] mem [0:511];
  always @(posedge REF_CLK_IN) begin
    if (RAM_WE_OUT) begin
      mem[RAM_ADDR_OUT] <= RAM_DATA_OUT;
    end
  end
endmodule
`default_nettype wire

// >>> sim/ilbw_writer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ilbw_chk (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic HW_EVENT_IN,
  input wire logic MON_EVENT_IN,
  input wire logic [15:0] MON_LOC_IN,
  input wire logic RT_EVENT_IN,
  input wire logic [15:0] RT_LOC_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic RAM_WE_OUT,
  input wire logic [8:0] RAM_ADDR_OUT,
  input wire logic [15:0] RAM_DATA_OUT
);
  logic [8:0] exp_ptr_reg;
  logic [15:0] mon_loc_reg;
  logic [15:0] rt_loc_reg;
  // loc words are held here, so a repeated event before logging would confuse them
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      exp_ptr_reg <= 9'h180;
      mon_loc_reg <= 16'h0000;
      rt_loc_reg <= 16'h0000;
    end else begin
      if (MON_EVENT_IN) mon_loc_reg <= MON_LOC_IN;
      if (RT_EVENT_IN) rt_loc_reg <= RT_LOC_IN;
      if (WR_IN && ADDR_IN == 4'h4) exp_ptr_reg <= 9'h180;
      else if (RAM_WE_OUT && RAM_ADDR_OUT[0]) exp_ptr_reg <= (RAM_ADDR_OUT == 9'h1bf) ? 9'h180 : RAM_ADDR_OUT + 9'h001;
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_range; RAM_WE_OUT |-> RAM_ADDR_OUT[8:6] == 3'h6; endproperty
  a_range: assert property (p_range) else $error("log write outside region");
  property p_pair; RAM_WE_OUT && !RAM_ADDR_OUT[0] |=> RAM_WE_OUT && RAM_ADDR_OUT == $past(RAM_ADDR_OUT) + 9'h001; endproperty
  a_pair: assert property (p_pair) else $error("ident word not followed by loc word");
  property p_gap; RAM_WE_OUT && RAM_ADDR_OUT[0] |=> !RAM_WE_OUT; endproperty
  a_gap: assert property (p_gap) else $error("pairs not separated");
  property p_ptr; RAM_WE_OUT && !RAM_ADDR_OUT[0] |-> RAM_ADDR_OUT == exp_ptr_reg; endproperty
  a_ptr: assert property (p_ptr) else $error("entry at wrong address");
  property p_hw; HW_EVENT_IN |-> ##[3:9] RAM_WE_OUT && RAM_ADDR_OUT[0] && RAM_DATA_OUT == 16'h0000; endproperty
  a_hw: assert property (p_hw) else $error("hardware loc word missing");
  property p_mon; MON_EVENT_IN |-> ##[4:10] RAM_WE_OUT && RAM_ADDR_OUT[0] && RAM_DATA_OUT == mon_loc_reg; endproperty
  a_mon: assert property (p_mon) else $error("monitor loc word missing");
  property p_rt; RT_EVENT_IN |-> ##[4:10] RAM_WE_OUT && RAM_ADDR_OUT[0] && RAM_DATA_OUT == rt_loc_reg; endproperty
  a_rt: assert property (p_rt) else $error("terminal loc word missing");
  property p_cnt; (RD_IN && ADDR_IN == 4'h0 && !RAM_WE_OUT) ##1 (RD_IN && ADDR_IN == 4'h0) |=> RDATA_OUT[15:9] == 7'h00; endproperty
  a_cnt: assert property (p_cnt) else $error("count not cleared by read");
endmodule
`default_nettype wire

// >>> sim/ilbw_writer_test.sv
`timescale 1ns/1ns
`default_nettype none
module ilbw_writer_test;
  logic REF_CLK_IN = '0, RST_IN = '1, HW_EVENT_IN = '0, MON_EVENT_IN = '0, RT_EVENT_IN = '0;
  logic RT_WAS_BUSY_IN = '0, WR_IN = '0, RD_IN = '0;
  logic [15:0] HW_IDENT_IN = '0, MON_IDENT_IN = '0, MON_LOC_IN = '0, RT_IDENT_IN = '0, RT_LOC_IN = '0, WDATA_IN = '0;
  logic [3:0] ADDR_IN = '0;
  wire logic [15:0] RDATA_OUT, RAM_DATA_OUT;
  wire logic IRQ_OUT, RAM_WE_OUT;
  wire logic [8:0] RAM_ADDR_OUT;
  int n_errors = 0, tests_run = 0;
  logic [15:0] d;
  logic [8:0] ptr = 9'h180;
  logic [35:0] r;
  // src one-hot hw/mon/rt, busy, ident, loc
  logic [35:0] rows [4] = '{{3'h1, 1'h0, 16'h8003, 16'h5555}, {3'h2, 1'h0, 16'h0041, 16'h0abc},
                            {3'h4, 1'h0, 16'h0203, 16'h0400}, {3'h4, 1'h1, 16'h0011, 16'h0410}};
  always #10 REF_CLK_IN = ~REF_CLK_IN;
  ilbw_writer dut (.REF_CLK_IN, .RST_IN, .HW_EVENT_IN, .HW_IDENT_IN, .MON_EVENT_IN, .MON_IDENT_IN, .MON_LOC_IN,
    .RT_EVENT_IN, .RT_IDENT_IN, .RT_LOC_IN, .RT_WAS_BUSY_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT,
    .IRQ_OUT, .RAM_WE_OUT, .RAM_ADDR_OUT, .RAM_DATA_OUT);
  ilbw_host_model host (.REF_CLK_IN, .RAM_WE_OUT, .RAM_ADDR_OUT, .RAM_DATA_OUT);
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge REF_CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= v;
    WR_IN <= 1'h1;
    @(posedge REF_CLK_IN);
    WR_IN <= 1'h0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge REF_CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'h1;
    @(posedge REF_CLK_IN);
    RD_IN <= 1'h0;
    @(negedge REF_CLK_IN);
    d = RDATA_OUT;
  endtask
  // fixed wait: a full three-source burst is logged within eleven cycles
  task ev(input logic [2:0] s, input logic [15:0] id, input logic [15:0] lc, input logic b);
    @(posedge REF_CLK_IN);
    {RT_EVENT_IN, MON_EVENT_IN, HW_EVENT_IN} <= s;
    {HW_IDENT_IN, MON_IDENT_IN, RT_IDENT_IN} <= {id, id, id};
    {MON_LOC_IN, RT_LOC_IN, RT_WAS_BUSY_IN} <= {lc, lc, b};
    @(posedge REF_CLK_IN);
    {RT_EVENT_IN, MON_EVENT_IN, HW_EVENT_IN} <= 3'h0;
    repeat (12) @(posedge REF_CLK_IN);
  endtask
  task look(input logic [15:0] id, input logic [15:0] lc);
    chk("ident word", host.mem[ptr], id);
    chk("loc word", host.mem[ptr + 9'h001], lc);
    ptr = (ptr == 9'h1be) ? 9'h180 : ptr + 9'h002;
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK_IN);
    RST_IN <= 1'h0;
    rd(4'h0);
    chk("pointer after reset", d, 16'h0180);
    wr(4'h1, 16'h0004);
    foreach (rows[i]) begin
      r = rows[i];
      ev(r[35:33], r[31:16], r[15:0], r[32]);
      look(r[35] ? {r[31:26], r[32], r[24:16]} : r[31:16], r[33] ? 16'h0000 : r[15:0]);
    end
    @(posedge REF_CLK_IN);
    ADDR_IN <= 4'h0;
    RD_IN <= 1'h1;
    @(posedge REF_CLK_IN);
    @(negedge REF_CLK_IN);
    chk("count and pointer", RDATA_OUT, 16'h0988);
    @(posedge REF_CLK_IN);
    RD_IN <= 1'h0;
    @(negedge REF_CLK_IN);
    chk("count cleared", RDATA_OUT, {7'h00, ptr});
    wr(4'h3, 16'h0007);
    ev(3'h7, 16'h0005, 16'h0777, 1'h1);
    @(negedge REF_CLK_IN);
    chk("irq raised", {15'h0000, IRQ_OUT}, 16'h0001);
    look(16'h0005, 16'h0000);
    look(16'h0005, 16'h0777);
    look(16'h0205, 16'h0777);
    rd(4'h2);
    chk("status", d, 16'h0007);
    repeat (2) @(posedge REF_CLK_IN);
    @(negedge REF_CLK_IN);
    chk("irq cleared", {15'h0000, IRQ_OUT}, 16'h0000);
    wr(4'h3, 16'h0000);
    ev(3'h1, 16'h0002, 16'h0000, 1'h0);
    @(negedge REF_CLK_IN);
    chk("irq masked", {15'h0000, IRQ_OUT}, 16'h0000);
    look(16'h0002, 16'h0000);
    rd(4'h2);
    chk("masked status", d, 16'h0001);
    repeat (26) begin
      ev(3'h1, 16'h0100, 16'h0000, 1'h0);
      look(16'h0100, 16'h0000);
    end
    wr(4'h4, 16'h0000);
    ptr = 9'h180;
    ev(3'h1, 16'h0040, 16'h0000, 1'h0);
    look(16'h0040, 16'h0000);
    rd(4'hf);
    chk("unmapped read", d, 16'h0000);
    wr(4'h5, 16'h0000);
    rd(4'h6);
    chk("ram readback", d, 16'h0040);
    repeat (100) ev(3'h1, 16'h0001, 16'h0000, 1'h0);
    rd(4'h0);
    chk("count saturated", {9'h000, d[15:9]}, 16'h007f);
    give_verdict;
  end
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
endmodule
bind ilbw_writer ilbw_chk u_chk (.REF_CLK_IN, .RST_IN, .HW_EVENT_IN, .MON_EVENT_IN, .MON_LOC_IN, .RT_EVENT_IN,
  .RT_LOC_IN, .ADDR_IN, .WR_IN, .RD_IN, .RDATA_OUT, .RAM_WE_OUT, .RAM_ADDR_OUT, .RAM_DATA_OUT);
`default_nettype wire
